// *** hdl/pulse_detect_event_regs.sv ***
// single/double pulse detection, config and source registers
// assumes register port and samples share clk; odr_tick marks
// each new sample; timer settings come from neighbour registers
// Behaviour
// - six per-axis single/double enables, reset zero
// - abort bit clear: latency pulses never abort
// - abort bit set: short latency pulse suspends double
// - latch bit selects event flag latching
// - only enabled axis and type get reported
// - event active set on any event
// - per-axis hit bits show source axis
// - double flag tells single from double
// - per-axis sign bits, one means negative
// - latched active event freezes all status
// - reading source clears it and interrupt
// - three 7-bit thresholds, bit 7 reads zero
// - threshold lsb fixed on 8 g range
// - low noise caps threshold at 4 g
// - pulse must fall back within time limit
// - pulses ignored during latency after first
// - second pulse starts inside window after latency
`timescale 1ns/1ps
`default_nettype none
module pulse_detect_event_regs #(
   parameter int AXES = pulse_pkg::AXES,
   parameter int ACC_W = pulse_pkg::ACC_W
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic odr_tick,
   input wire logic [AXES-1:0][ACC_W-1:0] accel,
   input wire logic low_noise,
   input wire pulse_pkg::timers_t timers,
   input wire pulse_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic pulse_irq
);
   // registers
   pulse_pkg::cfg_t cfg_reg;
   pulse_pkg::src_t src_reg;
   pulse_pkg::src_t src_next;
   logic [AXES-1:0][pulse_pkg::THS_W-1:0] ths_reg;
   logic [7:0] rdata_reg;
   pulse_pkg::pstate_t state_reg;
   pulse_pkg::pstate_t state_next;
   logic [AXES-1:0] mask_reg; // axes that started pulse one
   logic [AXES-1:0] sign_reg; // signs at pulse start
   logic lat_seen_reg; // pulse started inside latency
   logic lat_abort_reg; // that pulse also ended inside it
   // comparator outputs
   logic [AXES-1:0] above;
   logic [AXES-1:0] neg;
   // per-axis enables regrouped from the config layout
   wire [AXES-1:0] single_en = {cfg_reg.z_single_en,
      cfg_reg.y_single_en, cfg_reg.x_single_en};
   wire [AXES-1:0] double_en = {cfg_reg.z_double_en,
      cfg_reg.y_double_en, cfg_reg.x_double_en};
   wire [AXES-1:0] any_en = single_en | double_en;
   wire [AXES-1:0] dbl_mask = mask_reg & double_en;

   // address decode
   wire wr_cfg = reg_req.wr && reg_req.addr == pulse_pkg::ADDR_CFG;
   wire rd_src = reg_req.rd && reg_req.addr == pulse_pkg::ADDR_SRC;
   wire wr_src = reg_req.wr && reg_req.addr == pulse_pkg::ADDR_SRC;

   // per-axis comparators and threshold registers
   genvar i;
   generate
      for (i = 0; i < AXES; i++)
      begin : g_axis
         wire wr_ths = reg_req.wr &&
            reg_req.addr == pulse_pkg::ADDR_THS_X + 8'(i);
         axis_cmp i_axis_cmp (
            .sample(accel[i]),
            .ths(ths_reg[i]),
            .low_noise(low_noise),
            .above(above[i]),
            .neg(neg[i])
         );
         // bit 7 is never stored
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               ths_reg[i] <= pulse_pkg::THS_RST;
            else if (wr_ths)
               ths_reg[i] <= reg_req.wdata[pulse_pkg::THS_W-1:0];
         end
      end
   endgenerate

   // sequence conditions, all qualified by a sample tick
   wire start_any = odr_tick && |(above & any_en);
   wire first_end = odr_tick && !(|(above & mask_reg));
   wire win_start = odr_tick && |(above & dbl_mask);
   wire second_end = odr_tick && !(|(above & dbl_mask));
   wire lat_start = odr_tick && |(above & any_en);
   wire lat_quiet = odr_tick && !(|(above & any_en));
   logic tmr_exp;

   // one timer serves every phase since phases never overlap
   wire tmr_load = (state_reg != state_next);
   wire [pulse_pkg::TMR_W-1:0] tmr_val =
      (state_next == pulse_pkg::ST_LAT) ? timers.latency
      : (state_next == pulse_pkg::ST_WIN) ? timers.window
      : timers.time_limit;
   tick_timer i_tick_timer (
      .clk(clk),
      .resetn(resetn),
      .load(tmr_load),
      .load_val(tmr_val),
      .tick(odr_tick),
      .expired(tmr_exp)
   );

   // event reporting
   wire single_fire = state_reg == pulse_pkg::ST_FIRST && first_end
      && |(mask_reg & single_en);
   wire double_fire = state_reg == pulse_pkg::ST_SECOND
      && second_end;
   wire ev_fire = single_fire || double_fire;
   wire [AXES-1:0] ev_hit = double_fire ? dbl_mask
      : mask_reg & single_en;
   wire frozen = src_reg.event_active && cfg_reg.event_latch_en;

   // next state of the detection sequence
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         pulse_pkg::ST_IDLE:
            if (start_any)
               state_next = pulse_pkg::ST_FIRST;
         pulse_pkg::ST_FIRST:
            // pulse too long is dropped
            if (first_end)
               state_next = pulse_pkg::ST_LAT;
            else if (tmr_exp)
               state_next = pulse_pkg::ST_IDLE;
         pulse_pkg::ST_LAT:
            // latency runs even for single so a bounce is ignored
            if (tmr_exp)
               state_next = (lat_abort_reg || dbl_mask == '0)
                  ? pulse_pkg::ST_IDLE : pulse_pkg::ST_WIN;
         pulse_pkg::ST_WIN:
            if (win_start)
               state_next = pulse_pkg::ST_SECOND;
            else if (tmr_exp)
               state_next = pulse_pkg::ST_IDLE;
         pulse_pkg::ST_SECOND:
            // end need not fall inside the window, only the limit
            if (second_end || tmr_exp)
               state_next = pulse_pkg::ST_IDLE;
         default:
            state_next = pulse_pkg::ST_IDLE;
      endcase
   end

   // sequence state and capture of start axes and signs
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= pulse_pkg::ST_IDLE;
         mask_reg <= '0;
         sign_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == pulse_pkg::ST_IDLE && start_any)
         begin
            mask_reg <= above & any_en;
            sign_reg <= neg;
         end
         else if (state_reg == pulse_pkg::ST_WIN && win_start)
            sign_reg <= neg;
      end
   end

   // latency watch for the abort option
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lat_seen_reg <= 1'b0;
         lat_abort_reg <= 1'b0;
      end
      else if (state_reg != pulse_pkg::ST_LAT)
      begin
         lat_seen_reg <= 1'b0;
         lat_abort_reg <= 1'b0;
      end
      else
      begin
         if (lat_start)
            lat_seen_reg <= 1'b1;
         // clear abort bit leaves the sequence running
         if (lat_seen_reg && lat_quiet && cfg_reg.double_abort_ctl)
            lat_abort_reg <= 1'b1;
      end
   end

   // source register: new event wins over a same-cycle read
   always_comb
   begin
      src_next = src_reg;
      if (ev_fire && (!frozen || rd_src))
      begin
         src_next.event_active = 1'b1;
         {src_next.z_axis_hit, src_next.y_axis_hit,
            src_next.x_axis_hit} = ev_hit;
         src_next.double_flag = double_fire;
         {src_next.z_sign, src_next.y_sign,
            src_next.x_sign} = sign_reg & ev_hit;
      end
      else if (rd_src)
         src_next = pulse_pkg::SRC_RST;
   end

   // status and config registers; source writes fall through
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cfg_reg <= pulse_pkg::CFG_RST;
         src_reg <= pulse_pkg::SRC_RST;
      end
      else
      begin
         if (wr_cfg)
            cfg_reg <= reg_req.wdata;
         src_reg <= src_next;
      end
   end

   // read mux, unmapped offsets read zero
   wire [7:0] rd_mux =
      (reg_req.addr == pulse_pkg::ADDR_CFG) ? cfg_reg
      : (reg_req.addr == pulse_pkg::ADDR_SRC) ? src_reg
      : (reg_req.addr == pulse_pkg::ADDR_THS_X) ? {1'b0, ths_reg[0]}
      : (reg_req.addr == pulse_pkg::ADDR_THS_Y) ? {1'b0, ths_reg[1]}
      : (reg_req.addr == pulse_pkg::ADDR_THS_Z) ? {1'b0, ths_reg[2]}
      : pulse_pkg::RD_UNMAPPED;

   // read data holds until the next read
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rdata_reg <= pulse_pkg::RD_UNMAPPED;
      else if (reg_req.rd)
         rdata_reg <= rd_mux;
   end

   assign reg_rdata = rdata_reg;
   // interrupt follows event active, so reading clears it
   assign pulse_irq = src_reg.event_active;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_rd_clear;
      rd_src && !ev_fire |=> src_reg == pulse_pkg::SRC_RST && !pulse_irq;
   endproperty
   a_rd_clear: assert property (p_rd_clear)
      else $error("source not cleared by read");

   property p_ea_set;
      ev_fire |=> src_reg.event_active;
   endproperty
   a_ea_set: assert property (p_ea_set)
      else $error("event active not set");

   property p_freeze;
      frozen && !rd_src |=> $stable(src_reg);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("latched status changed");

   property p_wr_src;
      wr_src && !rd_src && !ev_fire |=> $stable(src_reg);
   endproperty
   a_wr_src: assert property (p_wr_src)
      else $error("source write took effect");

   // checks the stored hit bits, not the decode that produced them
   property p_enabled;
      ev_fire && (!frozen || rd_src)
         |=> ({src_reg.z_axis_hit, src_reg.y_axis_hit, src_reg.x_axis_hit}
         & ~(src_reg.double_flag ? $past(double_en) : $past(single_en))) == '0;
   endproperty
   a_enabled: assert property (p_enabled)
      else $error("disabled axis reported");

   property p_ths_bit7;
      reg_req.rd && reg_req.addr == pulse_pkg::ADDR_THS_Z |=> !reg_rdata[7];
   endproperty
   a_ths_bit7: assert property (p_ths_bit7)
      else $error("threshold bit 7 not zero");

   property p_abort;
      state_reg == pulse_pkg::ST_LAT && lat_abort_reg && tmr_exp
         |=> state_reg == pulse_pkg::ST_IDLE;
   endproperty
   a_abort: assert property (p_abort)
      else $error("double not suspended");

   property p_limit;
      // an older latched event may stand; only a new report is wrong
      state_reg == pulse_pkg::ST_FIRST && tmr_exp && !first_end && !rd_src
         |=> state_reg == pulse_pkg::ST_IDLE && $stable(src_reg);
   endproperty
   a_limit: assert property (p_limit)
      else $error("long pulse accepted");

   property p_cfg_wr;
      wr_cfg |=> cfg_reg == $past(reg_req.wdata) ##1 $stable(cfg_reg) || $past(wr_cfg);
   endproperty
   a_cfg_wr: assert property (p_cfg_wr)
      else $error("config write lost");

   c_single: cover property (single_fire ##1 src_reg.event_active);
   c_double: cover property (double_fire ##1 src_reg.double_flag);
   c_abort: cover property (lat_abort_reg ##[1:300] state_reg == pulse_pkg::ST_IDLE);
   c_clear: cover property (src_reg.event_active ##1 rd_src ##1 !pulse_irq);
endmodule : pulse_detect_event_regs
`default_nettype wire

// *** include/pulse_pkg.sv ***
// pulse detection register block: shared constants and types
// assumes one clock domain; samples arrive already scaled
package pulse_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] ADDR_CFG = 8'h21;
   localparam logic [7:0] ADDR_SRC = 8'h22;
   localparam logic [7:0] ADDR_THS_X = 8'h23;
   localparam logic [7:0] ADDR_THS_Y = 8'h24;
   localparam logic [7:0] ADDR_THS_Z = 8'h25;
   // geometry
   localparam int AXES = 3;
   localparam int THS_W = 7;
   localparam int ACC_W = 8;
   localparam int TMR_W = 8;
   // sample lsb equals threshold lsb (0.063 g) on fixed 8 g range
   localparam logic [THS_W-1:0] THS_MAX_LN = 7'h3f;
   // reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] SRC_RST = 8'h00;
   localparam logic [THS_W-1:0] THS_RST = 7'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
   localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;
   // config register layout, msb first
   typedef struct packed {
      logic double_abort_ctl;
      logic event_latch_en;
      logic z_double_en;
      logic z_single_en;
      logic y_double_en;
      logic y_single_en;
      logic x_double_en;
      logic x_single_en;
   } cfg_t;
   // source register layout, msb first
   typedef struct packed {
      logic event_active;
      logic z_axis_hit;
      logic y_axis_hit;
      logic x_axis_hit;
      logic double_flag;
      logic z_sign;
      logic y_sign;
      logic x_sign;
   } src_t;
   // one register access per cycle
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;
   // timer settings held by the neighbouring timer registers
   typedef struct packed {
      logic [TMR_W-1:0] time_limit;
      logic [TMR_W-1:0] latency;
      logic [TMR_W-1:0] window;
   } timers_t;
   // detection sequence
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FIRST = 3'b001,
      ST_LAT = 3'b010,
      ST_WIN = 3'b011,
      ST_SECOND = 3'b100
   } pstate_t;
endpackage : pulse_pkg

// *** hdl/axis_cmp.sv ***
// one axis: magnitude against threshold, plus sign
// assumes sample is two's complement on the same clock
`timescale 1ns/1ps
`default_nettype none
module axis_cmp #(
   parameter int ACC_W = pulse_pkg::ACC_W,
   parameter int THS_W = pulse_pkg::THS_W
) (
   input wire logic [ACC_W-1:0] sample,
   input wire logic [THS_W-1:0] ths,
   input wire logic low_noise,
   output logic above,
   output logic neg
);
   // negative sample means negative pulse
   logic [ACC_W-1:0] mag;
   logic [THS_W-1:0] eff;
   assign neg = sample[ACC_W-1];
   // -128 maps to 0x80, still correct unsigned
   assign mag = neg ? ACC_W'(-sample) : sample;
   // low noise caps the reachable threshold at 4 g
   assign eff = (low_noise && ths > pulse_pkg::THS_MAX_LN)
      ? pulse_pkg::THS_MAX_LN : ths;
   // detection starts only when strictly exceeded
   assign above = mag > ACC_W'(eff);
endmodule : axis_cmp
`default_nettype wire

// *** hdl/tick_timer.sv ***
// down counter in sample ticks, shared by all phases
// assumes load and tick come from the same clock
`timescale 1ns/1ps
`default_nettype none
module tick_timer #(
   parameter int W = pulse_pkg::TMR_W
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic tick,
   output logic expired
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   // expiry is the tick seen at zero
   assign expired = tick && (cnt_reg == '0);
   assign cnt_next = load ? load_val
      : (tick && cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg;
   // counter register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end
endmodule : tick_timer
`default_nettype wire

// *** tb/host_model.sv ***
// host side of the register port: one access at a time
// assumes the design takes a request on the edge after it is set
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk,
   output var pulse_pkg::reg_req_t reg_req
);
   // idle port from time zero
   initial reg_req = '0;
   // request stands for one edge, then the port goes idle again
   task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      reg_req <= '{a, w, ~w, d};
      @(posedge clk);
      reg_req <= '0;
   endtask : access
endmodule : host_model
`default_nettype wire

// *** tb/pulse_detect_event_regs_tb_top.sv ***
// bench for the pulse register block: host model drives the port
// assumes one 25 MHz clock; reads are checked one edge after the take
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("Error %s exp %h got %h", nm, e, g); end end
module pulse_detect_event_regs_tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic odr_tick = 1'b0;
   logic [2:0][7:0] accel = '0;
   logic low_noise = 1'b0;
   // short timers keep each sequence to a handful of ticks
   pulse_pkg::timers_t timers = '{8'h03, 8'h02, 8'h03};
   pulse_pkg::reg_req_t reg_req;
   logic [7:0] reg_rdata;
   logic pulse_irq;
   logic [7:0] exp_q[$];
   logic rd_d = 1'b0;
   int fail_count = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'd63161;

   pulse_detect_event_regs i_pulse_detect_event_regs (
      .clk(clk), .resetn(resetn), .odr_tick(odr_tick), .accel(accel), .low_noise(low_noise),
      .timers(timers), .reg_req(reg_req), .reg_rdata(reg_rdata), .pulse_irq(pulse_irq));
   host_model i_host_model (.clk(clk), .reg_req(reg_req));

   // free running clock
   initial forever #20 clk = ~clk;

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host_model.access(a, 1'b1, d);
   endtask : wr

   // expectation noted before the read goes out
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host_model.access(a, 1'b0, 8'h00);
   endtask : rd

   // one sample tick, spaced two cycles apart
   task automatic tk(input logic [2:0][7:0] s);
      @(posedge clk);
      odr_tick <= 1'b1;
      accel <= s;
      @(posedge clk);
      odr_tick <= 1'b0;
   endtask : tk

   task automatic pulse(input int ax, input logic [7:0] v);
      logic [2:0][7:0] s;
      s = '0;
      s[ax] = v;
      tk(s);
      tk('0);
   endtask : pulse

   // quiet ticks outlast latency plus window
   task automatic flush();
      repeat (8) tk('0);
   endtask : flush

   task automatic conclude();
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   // read data stands from the edge after the take
   always @(posedge clk)
   begin
      logic [7:0] e_now;
      if (rd_d)
      begin
         e_now = exp_q.pop_front();
         `CHK("read data", e_now, reg_rdata)
      end
      rd_d <= reg_req.rd;
   end

   // hang guard, far beyond the few hundred cycles used
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude();
   end

   initial
   begin
      logic [7:0] r;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      // reset values, plus one unmapped place
      for (int a = 8'h21; a <= 8'h26; a++) rd(8'(a), 8'h00);
      r = rnd();
      wr(pulse_pkg::ADDR_CFG, r);
      rd(pulse_pkg::ADDR_CFG, r);
      for (int a = 8'h23; a <= 8'h25; a++)
      begin
         r = rnd();
         wr(8'(a), r);
         rd(8'(a), {1'b0, r[6:0]});
         wr(8'(a), 8'h0a);
      end
      // single pulse per axis, y negative
      for (int i = 0; i < 3; i++)
      begin
         wr(pulse_pkg::ADDR_CFG, 8'h40 | (8'h01 << (2 * i)));
         pulse(i, (i == 1) ? 8'hec : 8'h14);
         @(negedge clk);
         `CHK("irq set", 1'b1, pulse_irq)
         wr(pulse_pkg::ADDR_SRC, 8'h00);
         rd(pulse_pkg::ADDR_SRC, 8'h80 | (8'h10 << i) | ((i == 1) ? 8'h02 : 8'h00));
         rd(pulse_pkg::ADDR_SRC, 8'h00);
         @(negedge clk);
         `CHK("irq clear", 1'b0, pulse_irq)
         flush();
      end
      // x single off: an x pulse must not show
      wr(pulse_pkg::ADDR_CFG, 8'h7e);
      pulse(0, 8'h14);
      flush();
      rd(pulse_pkg::ADDR_SRC, 8'h00);
      // double on z with a short pulse inside latency
      for (int ab = 0; ab < 2; ab++)
      begin
         wr(pulse_pkg::ADDR_CFG, {ab[0], 7'h60});
         pulse(2, 8'h14);
         pulse(2, 8'h14);
         tk('0);
         pulse(2, 8'h14);
         rd(pulse_pkg::ADDR_SRC, ab[0] ? 8'h00 : 8'hc8);
         flush();
      end
      // second pulse after the window closed starts afresh, no double
      wr(pulse_pkg::ADDR_CFG, 8'h60);
      pulse(2, 8'h14);
      flush();
      pulse(2, 8'h14);
      rd(pulse_pkg::ADDR_SRC, 8'h00);
      flush();
      // two events, latched or overwritten
      for (int le = 0; le < 2; le++)
      begin
         wr(pulse_pkg::ADDR_CFG, {1'b0, le[0], 6'h05});
         pulse(0, 8'h14);
         flush();
         pulse(1, 8'hec);
         rd(pulse_pkg::ADDR_SRC, le[0] ? 8'h90 : 8'ha2);
         flush();
      end
      // threshold must be exceeded, not just met
      wr(pulse_pkg::ADDR_CFG, 8'h41);
      for (int v = 10; v < 12; v++)
      begin
         pulse(0, 8'(v));
         rd(pulse_pkg::ADDR_SRC, (v == 11) ? 8'h90 : 8'h00);
         flush();
      end
      // pulse held past the time limit is not valid
      repeat (5) tk(24'h000014);
      tk('0);
      rd(pulse_pkg::ADDR_SRC, 8'h00);
      flush();
      // low noise caps the top threshold
      wr(pulse_pkg::ADDR_THS_X, 8'h7f);
      for (int ln = 0; ln < 2; ln++)
      begin
         low_noise <= ln[0];
         pulse(0, 8'h50);
         rd(pulse_pkg::ADDR_SRC, ln[0] ? 8'h90 : 8'h00);
         flush();
      end
      repeat (3) @(posedge clk);
      conclude();
   end
endmodule : pulse_detect_event_regs_tb_top
`default_nettype wire
